// ---- core/ama_pkg.sv ----
`default_nettype none
package ama_pkg;
	typedef enum logic [3:0] {
		AMA_CMD_CARRIER, AMA_CMD_AM_SRC, AMA_CMD_AM_SHAPE, AMA_CMD_AM_RATE,
		AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_CMD_AM_EN, AMA_CMD_FM_SRC, AMA_CMD_FM_SHAPE,
		AMA_CMD_FM_RATE, AMA_CMD_FM_EN, AMA_CMD_SWEEP_EN, AMA_CMD_BURST_EN,
		AMA_CMD_ARB_LEN, AMA_CMD_ARB_DATA
	} ama_cmd_t;
	typedef enum logic [1:0] {AMA_KEY_VALUE, AMA_KEY_MIN, AMA_KEY_MAX} ama_key_t;
	typedef enum logic [2:0] {
		AMA_SH_SINE, AMA_SH_SQUARE, AMA_SH_RAMP_UP, AMA_SH_RAMP_DOWN,
		AMA_SH_TRIANGLE, AMA_SH_NOISE, AMA_SH_USER
	} ama_shape_t;
	typedef enum logic [2:0] {
		AMA_CAR_SINE, AMA_CAR_SQUARE, AMA_CAR_RAMP, AMA_CAR_ARB,
		AMA_CAR_PULSE, AMA_CAR_NOISE, AMA_CAR_DC
	} ama_carrier_t;
	typedef enum logic [1:0] {AMA_MOD_NONE, AMA_MOD_AM, AMA_MOD_FM} ama_mod_t;

	localparam int RATE_W = 25;
	localparam int DEPTH_W = 7;
	localparam int SAMPLE_W = 16;
	localparam int ARB_AW = 12;
	localparam logic [16:0] ARB_MAX_LEN = 17'h10000;
	localparam logic [12:0] ARB_POINTS = 13'h1000;
	// Rates are held in millihertz.
	localparam logic [RATE_W-1:0] RATE_MIN = 25'h0000002;
	localparam logic [RATE_W-1:0] RATE_MAX = 25'h1312D00;
	localparam logic [RATE_W-1:0] AM_RATE_RESET = 25'h00186A0;
	localparam logic [RATE_W-1:0] FM_RATE_RESET = 25'h0002710;
	localparam logic [DEPTH_W-1:0] DEPTH_MIN = 7'h00;
	localparam logic [DEPTH_W-1:0] DEPTH_MAX = 7'h78;
	localparam logic [DEPTH_W-1:0] DEPTH_RESET = 7'h64;
	localparam logic signed [23:0] DEPTH_DIV = 24'sh0000C8;
	localparam logic signed [16:0] GAIN_HALF = 17'sh04000;
	localparam logic signed [16:0] GAIN_FULL = 17'sh07FFF;
	localparam logic signed [SAMPLE_W-1:0] FS_POS = 16'sh7FFF;
	localparam logic signed [SAMPLE_W-1:0] FS_NEG = -16'sh7FFF;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	localparam logic SRC_INT = 1'b0;
	localparam logic SRC_EXT = 1'b1;
	// Phase step per millihertz: 2^48 / (clock rate in mHz).
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam int PHASE_W = 48;
	localparam longint unsigned PHASE_MUL_L = (64'h1 << PHASE_W) / (CLK_HZ * 1000);
	localparam logic [11:0] PHASE_MUL = 12'(PHASE_MUL_L);
endpackage
`default_nettype wire

// ---- core/ama_wave_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module ama_wave_mem (
	input wire logic clk, // System clock.
	input wire logic wr_en, // Write strobe.
	input wire logic [11:0] wr_addr, // Write address.
	input wire logic [15:0] wr_data, // Write sample.
	input wire logic [11:0] rd_addr, // Read address.
	output logic [15:0] rd_data // Registered read sample.
);
	logic [15:0] mem [0:4095];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ---- core/ama_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module ama_ctrl (
	input wire logic REF_CLK, // 200 MHz system clock.
	input wire logic RST_N, // Synchronous reset, active low.
	input wire logic CMD_VALID, // Command strobe, one cycle.
	input wire logic CMD_QUERY, // High: read setting instead of writing it.
	input wire ama_pkg::ama_cmd_t CMD_CODE, // Setting addressed.
	input wire ama_pkg::ama_key_t CMD_KEY, // Value, minimum or maximum keyword.
	input wire logic [31:0] CMD_ARG, // Write value.
	output logic RESP_VALID, // Answer strobe, one cycle.
	output logic RESP_ERROR, // Command refused.
	output logic [31:0] RESP_DATA, // Query answer.
	input wire logic signed [15:0] CARRIER_SAMPLE, // Carrier waveform sample.
	input wire logic signed [15:0] EXT_MOD_LEVEL, // Digitised external input, full scale both ways.
	output logic signed [15:0] AM_OUT, // Output after amplitude modulation.
	output logic signed [15:0] FM_MOD_SAMPLE, // Internal frequency modulating sample.
	output logic AM_ENABLED, // Amplitude modulation active.
	output logic FM_ENABLED, // Frequency modulation active.
	output logic SWEEP_ENABLED, // Sweep active.
	output logic BURST_ENABLED, // Burst active.
	output logic FREQUENCY_MOD_SOURCE_SELECT_EXT, // Frequency modulation from external input.
	output logic [2:0] FM_SHAPE, // Frequency modulating shape.
	output logic [24:0] FM_RATE // Frequency modulating rate in mHz.
);
	import ama_pkg::*;

	ama_carrier_t carrier;
	ama_mod_t mod_mode;
	logic amplitude_mod_source_select;
	ama_shape_t amplitude_mod_shape_select;
	logic [RATE_W-1:0] amplitude_mod_rate;
	logic [DEPTH_W-1:0] amplitude_mod_depth;
	logic frequency_mod_source_select;
	ama_shape_t frequency_mod_shape_select;
	logic [RATE_W-1:0] frequency_mod_rate;
	logic [PHASE_W-1:0] am_phase, fm_phase;
	logic [15:0] lfsr;
	logic [4:0] arb_step;
	logic [4:0] arb_skip;
	logic [12:0] arb_len;
	logic [11:0] arb_wr_addr;
	logic arb_wr;
	logic [15:0] user_sample;
	logic [11:0] user_addr;
	logic [25:0] user_scaled;
	logic cmd_ok;
	logic [31:0] next_data;
	logic signed [15:0] am_mod;
	logic signed [23:0] depth_term;
	logic signed [16:0] gain;
	logic signed [33:0] product;

	function automatic logic carrier_ok(input ama_carrier_t c);
		return c inside {AMA_CAR_SINE, AMA_CAR_SQUARE, AMA_CAR_RAMP, AMA_CAR_ARB};
	endfunction

	function automatic logic [RATE_W-1:0] pick_rate(input ama_key_t k, input logic [31:0] a);
		unique case (k)
			AMA_KEY_MIN: return RATE_MIN;
			AMA_KEY_MAX: return RATE_MAX;
			default: return a[RATE_W-1:0];
		endcase
	endfunction

	function automatic logic rate_ok(input ama_key_t k, input logic [31:0] a);
		return (k != AMA_KEY_VALUE) || (a >= 32'(RATE_MIN) && a <= 32'(RATE_MAX));
	endfunction

	function automatic logic [PHASE_W-1:0] phase_step(input logic [RATE_W-1:0] r);
		return PHASE_W'(r) * PHASE_W'(PHASE_MUL);
	endfunction

	// Sine is a parabolic fit to the triangle: cheap and within about 6 percent.
	function automatic logic signed [15:0] shape_sample(input ama_shape_t s,
			input logic [15:0] u, input logic [15:0] n, input logic [15:0] usr);
		logic signed [17:0] tri_v;
		logic signed [35:0] sq;
		logic signed [17:0] par;
		tri_v = u[15] ? 18'sh17FFF - 18'({u, 1'b0}) : 18'({u, 1'b0}) - 18'sh08000;
		sq = tri_v * (tri_v[17] ? -tri_v : tri_v);
		// The parabola peaks one step past full scale, so it is held to the rails.
		par = (tri_v <<< 1) - 18'(sq >>> 15);
		unique case (s)
			AMA_SH_SQUARE: return u[15] ? FS_NEG : FS_POS;
			AMA_SH_RAMP_UP: return 16'(u - 16'h8000);
			AMA_SH_RAMP_DOWN: return 16'(16'h7FFF - u);
			AMA_SH_TRIANGLE: return 16'(tri_v);
			AMA_SH_NOISE: return n;
			AMA_SH_USER: return usr;
			default: return (par > 18'sh07FFF) ? FS_POS : ((par < -18'sh07FFF) ? FS_NEG : 16'(par));
		endcase
	endfunction

	assign cmd_ok = CMD_VALID && !CMD_QUERY;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			carrier <= AMA_CAR_SINE;
			mod_mode <= AMA_MOD_NONE;
			SWEEP_ENABLED <= 1'b0;
			BURST_ENABLED <= 1'b0;
		end else if (cmd_ok) begin
			unique case (CMD_CODE)
				AMA_CMD_CARRIER: begin
					if (mod_mode == AMA_MOD_NONE || carrier_ok(ama_carrier_t'(CMD_ARG[2:0]))) begin
						carrier <= ama_carrier_t'(CMD_ARG[2:0]);
					end
				end
				AMA_CMD_AM_EN: begin
					if (!CMD_ARG[0]) begin
						if (mod_mode == AMA_MOD_AM) mod_mode <= AMA_MOD_NONE;
					end else if (carrier_ok(carrier)) begin
						mod_mode <= AMA_MOD_AM;
						SWEEP_ENABLED <= 1'b0;
						BURST_ENABLED <= 1'b0;
					end
				end
				AMA_CMD_FM_EN: begin
					if (!CMD_ARG[0]) begin
						if (mod_mode == AMA_MOD_FM) mod_mode <= AMA_MOD_NONE;
					end else if (carrier_ok(carrier)) begin
						mod_mode <= AMA_MOD_FM;
						SWEEP_ENABLED <= 1'b0;
						BURST_ENABLED <= 1'b0;
					end
				end
				// Sweep or burst takes over and drops modulation, so the pair never overlaps.
				AMA_CMD_SWEEP_EN: begin
					SWEEP_ENABLED <= CMD_ARG[0];
					if (CMD_ARG[0]) mod_mode <= AMA_MOD_NONE;
				end
				AMA_CMD_BURST_EN: begin
					BURST_ENABLED <= CMD_ARG[0];
					if (CMD_ARG[0]) mod_mode <= AMA_MOD_NONE;
				end
				default: begin
				end
			endcase
		end
	end

	// Parameter registers are touched only by their own commands.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			amplitude_mod_source_select <= SRC_INT;
			amplitude_mod_shape_select <= AMA_SH_SINE;
			amplitude_mod_rate <= AM_RATE_RESET;
			amplitude_mod_depth <= DEPTH_RESET;
			frequency_mod_source_select <= SRC_INT;
			frequency_mod_shape_select <= AMA_SH_SINE;
			frequency_mod_rate <= FM_RATE_RESET;
		end else if (cmd_ok) begin
			unique case (CMD_CODE)
				AMA_CMD_AM_SRC: amplitude_mod_source_select <= CMD_ARG[0];
				AMA_CMD_AM_SHAPE: begin
					if (CMD_ARG[2:0] <= 3'(AMA_SH_USER)) begin
						amplitude_mod_shape_select <= ama_shape_t'(CMD_ARG[2:0]);
					end
				end
				AMA_CMD_AM_RATE: begin
					if (rate_ok(CMD_KEY, CMD_ARG)) begin
						amplitude_mod_rate <= pick_rate(CMD_KEY, CMD_ARG);
					end
				end
				AMA_CMD_AMPLITUDE_MOD_DEPTH: begin
					if (CMD_KEY == AMA_KEY_MIN) begin
						amplitude_mod_depth <= DEPTH_MIN;
					end else if (CMD_KEY == AMA_KEY_MAX) begin
						amplitude_mod_depth <= DEPTH_MAX;
					end else if (CMD_ARG <= 32'(DEPTH_MAX)) begin
						amplitude_mod_depth <= CMD_ARG[DEPTH_W-1:0];
					end
				end
				AMA_CMD_FM_SRC: frequency_mod_source_select <= CMD_ARG[0];
				AMA_CMD_FM_SHAPE: begin
					if (CMD_ARG[2:0] <= 3'(AMA_SH_USER)) begin
						frequency_mod_shape_select <= ama_shape_t'(CMD_ARG[2:0]);
					end
				end
				AMA_CMD_FM_RATE: begin
					if (rate_ok(CMD_KEY, CMD_ARG)) begin
						frequency_mod_rate <= pick_rate(CMD_KEY, CMD_ARG);
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Answers and refusals, one cycle after the command.
	always_comb begin
		next_data = 32'h0;
		unique case (CMD_CODE)
			AMA_CMD_CARRIER: next_data = 32'(carrier);
			AMA_CMD_AM_SRC: next_data = 32'(amplitude_mod_source_select);
			AMA_CMD_AM_SHAPE: next_data = 32'(amplitude_mod_shape_select);
			AMA_CMD_AM_RATE: next_data = 32'(CMD_KEY == AMA_KEY_VALUE ? amplitude_mod_rate
				: pick_rate(CMD_KEY, CMD_ARG));
			AMA_CMD_AMPLITUDE_MOD_DEPTH: next_data = 32'(CMD_KEY == AMA_KEY_MIN ? DEPTH_MIN
				: CMD_KEY == AMA_KEY_MAX ? DEPTH_MAX : amplitude_mod_depth);
			AMA_CMD_AM_EN: next_data = 32'(mod_mode == AMA_MOD_AM);
			AMA_CMD_FM_SRC: next_data = 32'(frequency_mod_source_select);
			AMA_CMD_FM_SHAPE: next_data = 32'(frequency_mod_shape_select);
			AMA_CMD_FM_RATE: next_data = 32'(CMD_KEY == AMA_KEY_VALUE ? frequency_mod_rate
				: pick_rate(CMD_KEY, CMD_ARG));
			AMA_CMD_FM_EN: next_data = 32'(mod_mode == AMA_MOD_FM);
			AMA_CMD_SWEEP_EN: next_data = 32'(SWEEP_ENABLED);
			AMA_CMD_BURST_EN: next_data = 32'(BURST_ENABLED);
			AMA_CMD_ARB_LEN: next_data = 32'(arb_len);
			default: next_data = 32'h0;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			RESP_VALID <= 1'b0;
			RESP_ERROR <= 1'b0;
			RESP_DATA <= 32'h0;
		end else begin
			RESP_VALID <= CMD_VALID;
			RESP_DATA <= (CMD_VALID && CMD_QUERY) ? next_data : 32'h0;
			RESP_ERROR <= 1'b0;
			if (cmd_ok) begin
				unique case (CMD_CODE)
					AMA_CMD_CARRIER: RESP_ERROR <= (mod_mode != AMA_MOD_NONE)
						&& !carrier_ok(ama_carrier_t'(CMD_ARG[2:0]));
					AMA_CMD_AM_EN, AMA_CMD_FM_EN: RESP_ERROR <= CMD_ARG[0] && !carrier_ok(carrier);
					AMA_CMD_AM_SHAPE, AMA_CMD_FM_SHAPE: RESP_ERROR <= CMD_ARG[2:0] > 3'(AMA_SH_USER);
					AMA_CMD_AM_RATE, AMA_CMD_FM_RATE: RESP_ERROR <= !rate_ok(CMD_KEY, CMD_ARG);
					AMA_CMD_AMPLITUDE_MOD_DEPTH: RESP_ERROR <= CMD_KEY == AMA_KEY_VALUE
						&& CMD_ARG > 32'(DEPTH_MAX);
					AMA_CMD_ARB_LEN: RESP_ERROR <= CMD_ARG == 32'h0 || CMD_ARG > 32'(ARB_MAX_LEN);
					default: RESP_ERROR <= 1'b0;
				endcase
			end
		end
	end

	// User shape loading keeps one sample in every arb_skip.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			arb_skip <= 5'h01;
			arb_step <= 5'h00;
			arb_len <= 13'h0000;
			arb_wr_addr <= 12'h000;
		end else if (cmd_ok && CMD_CODE == AMA_CMD_ARB_LEN && CMD_ARG != 32'h0
				&& CMD_ARG <= 32'(ARB_MAX_LEN)) begin
			arb_skip <= 5'((CMD_ARG + 32'(ARB_POINTS) - 32'h1) >> ARB_AW);
			arb_step <= 5'h00;
			arb_len <= 13'h0000;
			arb_wr_addr <= 12'h000;
		end else if (cmd_ok && CMD_CODE == AMA_CMD_ARB_DATA) begin
			arb_step <= (arb_step + 5'h01 == arb_skip) ? 5'h00 : arb_step + 5'h01;
			if (arb_step == 5'h00 && arb_len < ARB_POINTS) begin
				arb_len <= arb_len + 13'h0001;
				arb_wr_addr <= arb_wr_addr + 12'h001;
			end
		end
	end

	assign arb_wr = cmd_ok && CMD_CODE == AMA_CMD_ARB_DATA && arb_step == 5'h00
		&& arb_len < ARB_POINTS;
	assign user_scaled = am_phase[PHASE_W-1 -: 13] * arb_len;
	assign user_addr = user_scaled[24:13];

	ama_wave_mem u_wave_mem (
		.clk(REF_CLK),
		.wr_en(arb_wr),
		.wr_addr(arb_wr_addr),
		.wr_data(CMD_ARG[15:0]),
		.rd_addr(user_addr),
		.rd_data(user_sample)
	);

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			am_phase <= '0;
			fm_phase <= '0;
			lfsr <= LFSR_SEED;
		end else begin
			am_phase <= am_phase + phase_step(amplitude_mod_rate);
			fm_phase <= fm_phase + phase_step(frequency_mod_rate);
			lfsr <= lfsr[0] ? (lfsr >> 1) ^ LFSR_TAPS : lfsr >> 1;
		end
	end

	// External level replaces the internal shape; depth scales either one.
	always_comb begin
		am_mod = (amplitude_mod_source_select == SRC_EXT) ? EXT_MOD_LEVEL
			: shape_sample(amplitude_mod_shape_select, am_phase[PHASE_W-1 -: 16],
				lfsr, user_sample);
		depth_term = (24'(am_mod) * $signed({17'h0, amplitude_mod_depth})) / DEPTH_DIV;
		gain = GAIN_HALF + 17'(depth_term);
		if (gain > GAIN_FULL) gain = GAIN_FULL;
		if (gain < 17'sh0) gain = 17'sh0;
		product = CARRIER_SAMPLE * gain;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			AM_OUT <= 16'sh0000;
			FM_MOD_SAMPLE <= 16'sh0000;
		end else begin
			AM_OUT <= (mod_mode == AMA_MOD_AM) ? 16'(product >>> 15) : CARRIER_SAMPLE;
			FM_MOD_SAMPLE <= shape_sample(frequency_mod_shape_select,
				fm_phase[PHASE_W-1 -: 16], lfsr, user_sample);
		end
	end

	assign AM_ENABLED = mod_mode == AMA_MOD_AM;
	assign FM_ENABLED = mod_mode == AMA_MOD_FM;
	assign FREQUENCY_MOD_SOURCE_SELECT_EXT = frequency_mod_source_select;
	assign FM_SHAPE = 3'(frequency_mod_shape_select);
	assign FM_RATE = frequency_mod_rate;
endmodule
`default_nettype wire

// ---- bench/ama_ctrl_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module ama_ctrl_monitor import ama_pkg::*; (
	input wire logic REF_CLK, // Clock.
	input wire logic RST_N, // Reset.
	input wire logic CMD_VALID, // Strobe.
	input wire logic CMD_QUERY, // Query.
	input wire ama_pkg::ama_cmd_t CMD_CODE, // Code.
	input wire logic [31:0] CMD_ARG, // Value.
	input wire logic RESP_VALID, // Answer.
	input wire logic RESP_ERROR, // Refused.
	input wire logic signed [15:0] CARRIER_SAMPLE, // Carrier.
	input wire logic signed [15:0] AM_OUT, // Output.
	input wire logic AM_ENABLED, // AM on.
	input wire logic FM_ENABLED, // FM on.
	input wire logic SWEEP_ENABLED, // Sweep on.
	input wire logic BURST_ENABLED // Burst on.
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	logic wr;
	assign wr = CMD_VALID && !CMD_QUERY;
	a_resp_follows: assert property (CMD_VALID |=> RESP_VALID)
		else $error("no answer after command");
	a_resp_caused: assert property (RESP_VALID |-> $past(CMD_VALID))
		else $error("answer without command");
	a_query_accepted: assert property (CMD_VALID && CMD_QUERY |=> !RESP_ERROR)
		else $error("query refused");
	a_one_mod_mode: assert property (!(AM_ENABLED && FM_ENABLED))
		else $error("two modulation modes on");
	a_am_excl_sweep: assert property (AM_ENABLED |-> !SWEEP_ENABLED && !BURST_ENABLED)
		else $error("AM with sweep or burst");
	a_fm_excl_sweep: assert property (FM_ENABLED |-> !(SWEEP_ENABLED || BURST_ENABLED))
		else $error("FM with sweep or burst");
	a_am_enable_wins: assert property (wr && CMD_CODE == AMA_CMD_AM_EN && CMD_ARG[0]
		|=> RESP_ERROR || (AM_ENABLED && !FM_ENABLED && !SWEEP_ENABLED && !BURST_ENABLED))
		else $error("AM enable did not take over");
	a_am_disable: assert property (wr && CMD_CODE == AMA_CMD_AM_EN && !CMD_ARG[0] |=> !AM_ENABLED)
		else $error("AM stayed on");
	a_carrier_refused: assert property (wr && CMD_CODE == AMA_CMD_CARRIER &&
		CMD_ARG inside {[32'h4:32'h6]} && (AM_ENABLED || FM_ENABLED) |=> RESP_ERROR)
		else $error("bad carrier accepted");
	a_out_clamped: assert property (AM_ENABLED |=> ($past(CARRIER_SAMPLE) < 0)
		? (AM_OUT <= 0 && AM_OUT >= $past(CARRIER_SAMPLE))
		: (AM_OUT >= 0 && AM_OUT <= $past(CARRIER_SAMPLE)))
		else $error("output beyond carrier magnitude");
	a_off_passes: assert property (!AM_ENABLED ##1 !AM_ENABLED |-> AM_OUT == $past(CARRIER_SAMPLE))
		else $error("carrier not passed through");
	c_am_on: cover property (wr && CMD_CODE == AMA_CMD_AM_EN ##1 AM_ENABLED);
	c_refused: cover property (RESP_VALID && RESP_ERROR);
	c_fm_on: cover property ($rose(FM_ENABLED));
endmodule
bind ama_ctrl ama_ctrl_monitor u_mon (.REF_CLK(REF_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
	.CMD_QUERY(CMD_QUERY), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG), .RESP_VALID(RESP_VALID),
	.RESP_ERROR(RESP_ERROR), .CARRIER_SAMPLE(CARRIER_SAMPLE), .AM_OUT(AM_OUT),
	.AM_ENABLED(AM_ENABLED), .FM_ENABLED(FM_ENABLED), .SWEEP_ENABLED(SWEEP_ENABLED),
	.BURST_ENABLED(BURST_ENABLED));
`default_nettype wire

// ---- bench/ama_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module ama_host import ama_pkg::*; (
	input wire logic clk, // Clock.
	output var logic cmd_valid, // Strobe.
	output var logic cmd_query, // Query.
	output var ama_pkg::ama_cmd_t cmd_code, // Code.
	output var ama_pkg::ama_key_t cmd_key, // Keyword.
	output var logic [31:0] cmd_arg, // Value.
	input wire logic resp_error, // Refused.
	input wire logic [31:0] resp_data // Answer.
);
	initial begin
		cmd_valid = 1'b0;
		cmd_query = 1'b0;
		cmd_code = AMA_CMD_CARRIER;
		cmd_key = AMA_KEY_VALUE;
		cmd_arg = 32'h0;
	end
	// The argument is inverted once taken, so a stale value never looks valid.
	task automatic send(input logic q, input ama_cmd_t c, input ama_key_t k,
		input logic [31:0] a, output logic [31:0] d, output logic e);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_query = q;
		cmd_code = c;
		cmd_key = k;
		cmd_arg = a;
		// The answer stands only in the cycle after the taking edge.
		@(negedge clk);
		d = resp_data;
		e = resp_error;
		cmd_valid = 1'b0;
		cmd_arg = ~a;
	endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ama_pkg::*;
	logic REF_CLK, RST_N, CMD_VALID, CMD_QUERY, RESP_VALID, RESP_ERROR, err;
	ama_cmd_t CMD_CODE;
	ama_key_t CMD_KEY;
	logic [31:0] CMD_ARG, RESP_DATA, rd;
	logic signed [15:0] CARRIER_SAMPLE, EXT_MOD_LEVEL, AM_OUT, FM_MOD_SAMPLE;
	logic AM_ENABLED, FM_ENABLED, SWEEP_ENABLED, BURST_ENABLED, FREQUENCY_MOD_SOURCE_SELECT_EXT;
	logic [2:0] FM_SHAPE;
	logic [24:0] FM_RATE;
	int fails, check_count, hi;
	ama_ctrl uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID),
		.CMD_QUERY(CMD_QUERY), .CMD_CODE(CMD_CODE), .CMD_KEY(CMD_KEY), .CMD_ARG(CMD_ARG),
		.RESP_VALID(RESP_VALID), .RESP_ERROR(RESP_ERROR), .RESP_DATA(RESP_DATA),
		.CARRIER_SAMPLE(CARRIER_SAMPLE), .EXT_MOD_LEVEL(EXT_MOD_LEVEL), .AM_OUT(AM_OUT),
		.FM_MOD_SAMPLE(FM_MOD_SAMPLE), .AM_ENABLED(AM_ENABLED), .FM_ENABLED(FM_ENABLED),
		.SWEEP_ENABLED(SWEEP_ENABLED), .BURST_ENABLED(BURST_ENABLED),
		.FREQUENCY_MOD_SOURCE_SELECT_EXT(FREQUENCY_MOD_SOURCE_SELECT_EXT), .FM_SHAPE(FM_SHAPE), .FM_RATE(FM_RATE));
	ama_host host (.clk(REF_CLK), .cmd_valid(CMD_VALID), .cmd_query(CMD_QUERY),
		.cmd_code(CMD_CODE), .cmd_key(CMD_KEY), .cmd_arg(CMD_ARG),
		.resp_error(RESP_ERROR), .resp_data(RESP_DATA));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input ama_cmd_t c, input ama_key_t k, input logic [31:0] a);
		host.send(1'b0, c, k, a, rd, err);
	endtask
	task sg(input ama_cmd_t c, input ama_key_t k, input logic [31:0] a, input logic e,
		input logic [31:0] v);
		wr(c, k, a);
		check(32'(err), 32'(e));
		host.send(1'b1, c, AMA_KEY_VALUE, 32'h0, rd, err);
		check(rd, v);
	endtask
	task qry(input ama_cmd_t c, input logic [31:0] v);
		host.send(1'b1, c, AMA_KEY_VALUE, 32'h0, rd, err);
		check(rd, v);
	endtask
	// Loading keeps one sample in every ceil(n / points), the first one included.
	function automatic int arb_kept(input int n);
		int s;
		s = (n + int'(ARB_POINTS) - 1) / int'(ARB_POINTS);
		return (n + s - 1) / s;
	endfunction
	// Gain is one half plus depth times level over two hundred, held to [0, 1].
	function automatic logic signed [15:0] am_exp(int c, int m, int d);
		longint g;
		g = 16384 + (longint'(d) * m * 16384) / (100 * 32767);
		g = (g < 0) ? 0 : ((g > 32767) ? 32767 : g);
		return 16'((longint'(c) * g) >>> 15);
	endfunction
	task ext_check(input int c, input int m, input int d);
		int e;
		wr(AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_KEY_VALUE, 32'(d));
		CARRIER_SAMPLE = 16'(c);
		EXT_MOD_LEVEL = 16'(m);
		repeat (4) @(negedge REF_CLK);
		e = am_exp(c, m, d);
		check(((AM_OUT - e) < 5 && (e - AM_OUT) < 5) ? 32'(e) : 32'(AM_OUT), 32'(e));
	endtask
	initial begin
		REF_CLK = 1'b0;
		forever #2.5 REF_CLK = ~REF_CLK;
	end
	initial begin
		repeat (40000) @(posedge REF_CLK);
		fails++;
		summarize();
	end
	initial begin
		void'($urandom(32'h4648B98E));
		RST_N = 1'b0;
		CARRIER_SAMPLE = 16'h0000;
		EXT_MOD_LEVEL = 16'h0000;
		repeat (6) @(negedge REF_CLK);
		RST_N = 1'b1;
		sg(AMA_CMD_FM_RATE, AMA_KEY_VALUE, 32'h0, 1'b1, 32'(FM_RATE_RESET));
		check(32'(FM_RATE), 32'(FM_RATE_RESET));
		qry(AMA_CMD_AM_SRC, 32'(SRC_INT));
		sg(AMA_CMD_AM_RATE, AMA_KEY_VALUE, 32'h1, 1'b1, 32'(AM_RATE_RESET));
		sg(AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_KEY_VALUE, 32'h79, 1'b1, 32'(DEPTH_RESET));
		sg(AMA_CMD_AM_SHAPE, AMA_KEY_VALUE, 32'h7, 1'b1, 32'(AMA_SH_SINE));
		sg(AMA_CMD_AM_RATE, AMA_KEY_VALUE, 32'h1312D01, 1'b1, 32'(AM_RATE_RESET));
		sg(AMA_CMD_AM_RATE, AMA_KEY_MIN, 32'h0, 1'b0, 32'(RATE_MIN));
		sg(AMA_CMD_AM_RATE, AMA_KEY_MAX, 32'h0, 1'b0, 32'(RATE_MAX));
		sg(AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_KEY_MIN, 32'h0, 1'b0, 32'(DEPTH_MIN));
		sg(AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_KEY_MAX, 32'h0, 1'b0, 32'(DEPTH_MAX));
		sg(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h0, 1'b0, 32'h0);
		for (int i = 0; i < 7; i++) begin
			sg(AMA_CMD_FM_SHAPE, AMA_KEY_VALUE, 32'(i), 1'b0, 32'(i));
			check(32'(FM_SHAPE), 32'(i));
			sg(AMA_CMD_AM_SHAPE, AMA_KEY_VALUE, 32'(i), 1'b0, 32'(i));
		end
		sg(AMA_CMD_FM_SRC, AMA_KEY_VALUE, 32'h1, 1'b0, 32'h1);
		check(32'(FREQUENCY_MOD_SOURCE_SELECT_EXT), 32'h1);
		wr(AMA_CMD_SWEEP_EN, AMA_KEY_VALUE, 32'h1);
		sg(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h1, 1'b0, 32'h1);
		check(32'({AM_ENABLED, SWEEP_ENABLED}), 32'h2);
		wr(AMA_CMD_BURST_EN, AMA_KEY_VALUE, 32'h1);
		wr(AMA_CMD_FM_EN, AMA_KEY_VALUE, 32'h1);
		check(32'({AM_ENABLED, FM_ENABLED, BURST_ENABLED}), 32'h2);
		wr(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h1);
		check(32'({AM_ENABLED, FM_ENABLED}), 32'h2);
		sg(AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_KEY_VALUE, 32'h4B, 1'b0, 32'h4B);
		wr(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h0);
		qry(AMA_CMD_AM_SHAPE, 32'h6);
		qry(AMA_CMD_AMPLITUDE_MOD_DEPTH, 32'h4B);
		sg(AMA_CMD_CARRIER, AMA_KEY_VALUE, 32'h4, 1'b0, 32'h4);
		sg(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h1, 1'b1, 32'h0);
		wr(AMA_CMD_CARRIER, AMA_KEY_VALUE, 32'h0);
		wr(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h1);
		for (int i = 0; i < 8; i++) begin
			wr(AMA_CMD_CARRIER, AMA_KEY_VALUE, 32'(i));
			check(32'(err), 32'(i > 3));
		end
		wr(AMA_CMD_CARRIER, AMA_KEY_VALUE, 32'h0);
		wr(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h0);
		sg(AMA_CMD_AM_SRC, AMA_KEY_VALUE, 32'h1, 1'b0, 32'h1);
		wr(AMA_CMD_AM_EN, AMA_KEY_VALUE, 32'h1);
		ext_check(20000, 32767, 100);
		ext_check(20000, -32767, 100);
		ext_check(20000, 0, 100);
		ext_check(-32767, 32767, 120);
		ext_check(32767, 20000, 120);
		for (int i = 0; i < 30; i++)
			ext_check(int'($urandom_range(65534)) - 32767, int'($urandom_range(65534)) - 32767,
				int'($urandom_range(120)));
		// Internal square at the top rate spans 10000 cycles; a high half is counted.
		wr(AMA_CMD_AM_SRC, AMA_KEY_VALUE, 32'h0);
		wr(AMA_CMD_AM_SHAPE, AMA_KEY_VALUE, 32'(AMA_SH_SQUARE));
		wr(AMA_CMD_FM_SHAPE, AMA_KEY_VALUE, 32'(AMA_SH_SQUARE));
		wr(AMA_CMD_AM_RATE, AMA_KEY_MAX, 32'h0);
		wr(AMA_CMD_AMPLITUDE_MOD_DEPTH, AMA_KEY_VALUE, 32'h64);
		CARRIER_SAMPLE = 16'h3E80;
		EXT_MOD_LEVEL = 16'h8001;
		hi = 0;
		repeat (10000) begin
			@(negedge REF_CLK);
			hi += (AM_OUT > 16'sh1F40) ? 1 : 0;
		end
		check((hi > 4950 && hi < 5050) ? 32'd5000 : 32'(hi), 32'd5000);
		check(32'(FM_MOD_SAMPLE == FS_POS || FM_MOD_SAMPLE == FS_NEG), 32'h1);
		sg(AMA_CMD_ARB_LEN, AMA_KEY_VALUE, 32'h0, 1'b1, 32'h0);
		sg(AMA_CMD_ARB_LEN, AMA_KEY_VALUE, 32'h10001, 1'b1, 32'h0);
		wr(AMA_CMD_ARB_LEN, AMA_KEY_VALUE, 32'd4097);
		for (int i = 0; i < 4097; i++)
			wr(AMA_CMD_ARB_DATA, AMA_KEY_VALUE, $urandom());
		qry(AMA_CMD_ARB_LEN, 32'(arb_kept(4097)));
		summarize();
	end
endmodule
`default_nettype wire
